/* core/diag_pkg.sv */
// Constants and carrier types for the diagnostic function handler
package diag_pkg;
  localparam int WORD_W = 36;
  // Function codes, control word bits 31-35
  localparam logic [4:0] FN_ERR = 5'h00;
  localparam logic [4:0] FN_LOOP = 5'h01;
  localparam logic [4:0] FN_PROM = 5'h02;
  localparam logic [4:0] FN_FIXED = 5'h03;
  // Field positions, bit 00 is the most significant bit of the word
  localparam int UNIT_LO = 0;
  localparam int UNIT_HI = 4;
  localparam int FN_LO = 31;
  localparam int FN_HI = 35;
  localparam int ERR_CLR = 5;
  localparam int CRAM_SUM = 0;
  localparam int LB_EN = 12;
  localparam int LB_GRP_LO = 13;
  localparam int LB_GRP_HI = 14;
  localparam int OFFL = 25;
  localparam int INIT_LO = 26;
  localparam int INIT_HI = 27;
  localparam int COND_WE = 28;
  localparam int TYPE_LO = 8;
  localparam int TYPE_HI = 11;
  localparam int PROM_GRP_LO = 9;
  localparam int PROM_GRP_HI = 10;
  localparam int PROM_FLD_LO = 11;
  localparam int PROM_FLD_HI = 12;
  localparam int PROM_WD_LO = 13;
  localparam int PROM_WD_HI = 14;
  localparam int SIG_SEL_LO = 23;
  localparam int SIG_SEL_HI = 27;
  localparam int ERRWD_LO = 5;
  localparam int ERRWD_HI = 6;
  localparam int PDATA_LO = 7;
  localparam int PDATA_HI = 14;
  localparam int ARR_LO = 20;
  localparam int ARR_HI = 27;
  localparam int TIM_ERR = 28;
  localparam int SPARE_ERR = 29;
  localparam int ADDR_ERR = 30;
  localparam int ACK_BIT = 10;
  localparam int DV_LO = 11;
  localparam int DV_HI = 13;
  localparam int ACK_WE = 14;
  localparam int DV_WE = 15;
  localparam int FV_LO = 20;
  localparam int FV_HI = 27;
  // Reset values
  localparam logic [1:0] INIT_RST = 2'h0;
  localparam logic OFFLINE_RST = 1'b0;
  // Host samples the status four clocks after the strobe
  localparam int SAMPLE_CYCLES = 4;
  localparam logic [2:0] DRIVE_LAST = 3'(SAMPLE_CYCLES + 1);
  typedef struct packed {
    logic [1:0] group;
    logic [1:0] field;
    logic [1:0] word;
  } prom_sel_t;
  typedef struct packed {
    logic ack;
    logic [2:0] dv;
  } fixed_entry_t;
  typedef enum {ST_IDLE, ST_EXEC, ST_DRIVE} diag_state_t;
endpackage

/* core/diag_ctrl.sv */
// Diagnostic function 0-3 handler of the memory controller
// Operation
// - Bits 00-04 pick the controller, bits 31-35 the function to decode.
// - Status word driven after strobe; host samples it four clocks later.
// - Function 1 bit 12 enables loopback, bits 13-14 pick group 0-2.
// - Function 1 bit 28 gates updates of the stored init state.
// - Two-bit init state: powered, RAMs loaded, addr RAM loaded, done.
// - Function 1 bit 25 zero enables controller, one takes it off-line.
// - Function 1 status bits 08-11 carry a fixed memory type code.
// - Function 1 status bits 12-14 echo loopback settings of this cycle.
// - Function 2 bits 09-12 select one of twelve PROM chips.
// - Function 2 bits 13-14 select one of the first four PROM words.
// - Function 2 field 23-27 zero returns PROM data, else signals.
// - Function 2 status bits 05-06 give word index of last error.
// - Function 2 status bits 20-27 return the array address register.
// - Function 2 status bits 28-30 flag timing, spare, address RAM errors.
// - Function 0 status bit 00 summarises any control RAM parity error.
// - Function 3 bit 14 loads acknowledge RAM, bit 15 data-valid RAM.
// - Function 3 bits 20-27 address the fixed value RAMs.
// - Function 3 status bits 10-13 return the ack and data-valid bits.
`timescale 1ns/10ps
`default_nettype none
module diag_ctrl
  import diag_pkg::*;
#(
  parameter logic [3:0] TYPE_CODE = 4'hA, // arbitrary identification value
  parameter int FV_DEPTH = 256
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [0:4] unit_id,
  input wire logic diag_strobe,
  input wire logic [0:35] bus_data_in,
  output logic [0:35] bus_data_out,
  output logic bus_data_oe,
  output logic loopback_en,
  output logic [1:0] loopback_group,
  output logic [1:0] init_state,
  output logic offline,
  output prom_sel_t prom_sel,
  input wire logic [7:0] prom_data,
  output logic [4:0] diag_sig_sel,
  input wire logic [7:0] diag_sig_data,
  input wire logic [1:0] error_word_index,
  input wire logic [7:0] array_address_register,
  input wire logic timing_ram_parity_error,
  input wire logic spare_ram_parity_error,
  input wire logic addr_response_ram_parity_error,
  input wire logic [7:0] fv_addr,
  output fixed_entry_t fv_entry
);

  // The RAM address field is eight bits, so no other depth can be served
  if (FV_DEPTH != 256) begin : g_depth_check
    $error("FV_DEPTH must be 256 to match the 8-bit RAM address");
  end

  diag_state_t state;
  logic [2:0] cyc;
  logic [0:35] cw;
  logic [2:0] err_flags; // timing, spare, address response
  logic ack_ram [FV_DEPTH];
  logic [2:0] dv_ram [FV_DEPTH];
  logic [4:0] fn;
  logic accept;
  logic [7:0] fv_loc;
  logic [0:35] next_status;
  logic [2:0] err_set;
  logic [2:0] err_clr;

  // Control word fields
  assign fn = cw[FN_LO:FN_HI];
  assign fv_loc = cw[FV_LO:FV_HI];
  // Strobes while a cycle is busy are ignored, not queued
  assign accept = (state == ST_IDLE) && diag_strobe &&
                  (bus_data_in[UNIT_LO:UNIT_HI] == unit_id);

  // Cycle sequencer: capture, execute, then drive status
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cyc <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept) begin
            state <= ST_EXEC;
            cyc <= 3'h1;
          end
        end
        ST_EXEC: begin
          state <= ST_DRIVE;
          cyc <= 3'h2;
        end
        ST_DRIVE: begin
          if (cyc == DRIVE_LAST) begin
            state <= ST_IDLE;
            cyc <= 3'h0;
          end else begin
            cyc <= cyc + 3'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          cyc <= 3'h0;
        end
      endcase
    end
  end

  // Port data buffer holds the control word for the whole cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cw <= '0;
    end else if (accept) begin
      cw <= bus_data_in;
    end
  end

  // Function 1 loopback settings
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loopback_en <= 1'b0;
      loopback_group <= 2'h0;
    end else if (state == ST_EXEC && fn == FN_LOOP) begin
      loopback_en <= cw[LB_EN];
      loopback_group <= cw[LB_GRP_LO:LB_GRP_HI];
    end
  end

  // Function 1 state conditions; bit 25 applies on every function 1
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_state <= INIT_RST;
      offline <= OFFLINE_RST;
    end else if (state == ST_EXEC && fn == FN_LOOP) begin
      offline <= cw[OFFL];
      if (cw[COND_WE]) begin
        init_state <= cw[INIT_LO:INIT_HI];
      end
    end
  end

  // Control RAM error flags; a new error beats a clear in the same cycle
  assign err_set = {timing_ram_parity_error, spare_ram_parity_error,
                    addr_response_ram_parity_error};
  assign err_clr = (state == ST_EXEC && fn == FN_ERR && cw[ERR_CLR]) ?
                   3'h7 : 3'h0;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_flags <= 3'h0;
    end else begin
      err_flags <= (err_flags & ~err_clr) | err_set;
    end
  end

  // PROM and signal selectors straight from the stored control word
  // Group, field and word lie side by side in bits 09-14, one driver
  assign prom_sel = prom_sel_t'(cw[PROM_GRP_LO:PROM_WD_HI]);
  assign diag_sig_sel = cw[SIG_SEL_LO:SIG_SEL_HI];

  // Fixed value RAM loads; no enables leaves the RAM untouched
  always_ff @(posedge clk) begin
    if (state == ST_EXEC && fn == FN_FIXED) begin
      if (cw[ACK_WE]) begin
        ack_ram[fv_loc] <= cw[ACK_BIT];
      end
      if (cw[DV_WE]) begin
        dv_ram[fv_loc] <= cw[DV_LO:DV_HI];
      end
    end
  end

  // Lookup port for the controller's own cycle logic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fv_entry <= '0;
    end else begin
      fv_entry <= {ack_ram[fv_addr], dv_ram[fv_addr]};
    end
  end

  // Status word; a load shows the written value, bypassing the old entry
  always_comb begin
    next_status = '0;
    case (fn)
      FN_ERR: begin
        next_status[CRAM_SUM] = |err_flags;
      end
      FN_LOOP: begin
        next_status[TYPE_LO:TYPE_HI] = TYPE_CODE;
        next_status[LB_EN] = cw[LB_EN];
        next_status[LB_GRP_LO:LB_GRP_HI] = cw[LB_GRP_LO:LB_GRP_HI];
        next_status[OFFL] = offline;
        next_status[INIT_LO:INIT_HI] = init_state;
      end
      FN_PROM: begin
        next_status[ERRWD_LO:ERRWD_HI] = error_word_index;
        next_status[PDATA_LO:PDATA_HI] = (diag_sig_sel == 5'h00) ?
                                         prom_data : diag_sig_data;
        next_status[ARR_LO:ARR_HI] = array_address_register;
        next_status[TIM_ERR] = err_flags[2];
        next_status[SPARE_ERR] = err_flags[1];
        next_status[ADDR_ERR] = err_flags[0];
      end
      FN_FIXED: begin
        next_status[ACK_BIT] = cw[ACK_WE] ? cw[ACK_BIT] :
                               ack_ram[fv_loc];
        next_status[DV_LO:DV_HI] = cw[DV_WE] ? cw[DV_LO:DV_HI] :
                                   dv_ram[fv_loc];
      end
      default: begin
        next_status = '0;
      end
    endcase
  end

  // Status register loaded at the end of execution, dropped when idle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_data_out <= '0;
    end else if (state == ST_EXEC) begin
      bus_data_out <= next_status;
    end else if (state == ST_IDLE) begin
      bus_data_out <= '0;
    end
  end

  assign bus_data_oe = (state == ST_DRIVE);

  // Checks
  property p_drive_window;
    @(posedge clk) disable iff (sys_rst)
    accept |=> !bus_data_oe ##1 bus_data_oe [*4] ##1 !bus_data_oe;
  endproperty
  a_drive_window: assert property (p_drive_window)
    else $error("status not driven in cycles 2 to 5");

  property p_ignore_other_unit;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_IDLE && diag_strobe &&
     bus_data_in[UNIT_LO:UNIT_HI] != unit_id) |=> state == ST_IDLE;
  endproperty
  a_ignore_other_unit: assert property (p_ignore_other_unit)
    else $error("controller answered another unit number");

  property p_loopback;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && fn == FN_LOOP) |=>
      loopback_en == $past(cw[LB_EN]) &&
      bus_data_out[LB_EN] == loopback_en &&
      bus_data_out[LB_GRP_LO:LB_GRP_HI] == loopback_group;
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("loopback setting or echo wrong");

  property p_cond_hold;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && !(fn == FN_LOOP && cw[COND_WE])) |=>
      $stable(init_state);
  endproperty
  a_cond_hold: assert property (p_cond_hold)
    else $error("init state changed without enable");

  property p_offline;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && fn == FN_LOOP) |=> offline == $past(cw[OFFL]);
  endproperty
  a_offline: assert property (p_offline)
    else $error("off-line bit not taken");

  property p_type_code;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_DRIVE && fn == FN_LOOP) |->
      bus_data_out[TYPE_LO:TYPE_HI] == TYPE_CODE;
  endproperty
  a_type_code: assert property (p_type_code)
    else $error("type code wrong");

  property p_set_wins;
    @(posedge clk) disable iff (sys_rst)
    timing_ram_parity_error |=> err_flags[2];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("timing RAM error lost");

  property p_summary;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && fn == FN_ERR && !cw[ERR_CLR]) |=>
      bus_data_out[CRAM_SUM] == $past(|err_flags);
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary error bit wrong");

  property p_fixed_readback;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && fn == FN_FIXED && cw[ACK_WE]) |=>
      ##1 bus_data_out[ACK_BIT] == ack_ram[fv_loc];
  endproperty
  a_fixed_readback: assert property (p_fixed_readback)
    else $error("acknowledge RAM load not read back");

  property p_prom_mux;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && fn == FN_PROM && diag_sig_sel == 5'h00) |=>
      bus_data_out[PDATA_LO:PDATA_HI] == $past(prom_data);
  endproperty
  a_prom_mux: assert property (p_prom_mux)
    else $error("PROM data not returned");

  // Init state taken from the control word only under its enable
  property p_init_load;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && fn == FN_LOOP && cw[COND_WE]) |=>
      init_state == $past(cw[INIT_LO:INIT_HI]);
  endproperty
  a_init_load: assert property (p_init_load)
    else $error("init state not loaded");

  property p_error_detail;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && fn == FN_PROM) |=>
      bus_data_out[ERRWD_LO:ERRWD_HI] == $past(error_word_index) &&
      bus_data_out[ARR_LO:ARR_HI] == $past(array_address_register);
  endproperty
  a_error_detail: assert property (p_error_detail)
    else $error("error word index or array address wrong");

  // A read-only cycle must not disturb the addressed entry
  property p_read_only;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && fn == FN_FIXED && !cw[ACK_WE] && !cw[DV_WE]) |=>
      $stable(ack_ram[fv_loc]) && $stable(dv_ram[fv_loc]);
  endproperty
  a_read_only: assert property (p_read_only)
    else $error("fixed value RAM changed on a read-only cycle");

  property p_unused_zero;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_DRIVE && fn > FN_FIXED) |-> bus_data_out == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unhandled function returned nonzero status");

  // Stale status must not linger on the lines after the window
  property p_idle_zero;
    @(posedge clk) disable iff (sys_rst)
    state == ST_IDLE |=> bus_data_out == '0;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("status not cleared while idle");

  c_fn1: cover property (@(posedge clk)
    accept && bus_data_in[FN_LO:FN_HI] == FN_LOOP);
  c_fn2: cover property (@(posedge clk)
    accept && bus_data_in[FN_LO:FN_HI] == FN_PROM);
  c_fn3_load: cover property (@(posedge clk)
    state == ST_EXEC && fn == FN_FIXED && cw[DV_WE]);
  c_err_clear: cover property (@(posedge clk) err_clr != 3'h0);

endmodule
`default_nettype wire

/* verif/diag_host_model.sv */
// Host model that issues diagnostic cycles and samples the status word
`timescale 1ns/10ps
`default_nettype none
module diag_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [0:35] ctrl,
  input wire logic [0:35] bus_data_out,
  input wire logic bus_data_oe,
  output logic diag_strobe,
  output logic [0:35] bus_data_in,
  output logic [36:0] seen,
  output logic done
);
  logic busy;
  logic [2:0] cnt;
  // Released data lines toggle each cycle so stale words cannot match
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      diag_strobe <= 1'b0;
      bus_data_in <= '0;
      busy <= 1'b0;
      cnt <= 3'h0;
      done <= 1'b0;
      seen <= '0;
    end else begin
      done <= 1'b0;
      if (diag_strobe) begin
        diag_strobe <= 1'b0;
        bus_data_in <= ~bus_data_in;
        busy <= 1'b1;
        cnt <= 3'h1;
      end else if (busy) begin
        bus_data_in <= ~bus_data_in;
        cnt <= cnt + 3'h1;
        // Status taken four clocks after the strobe edge
        if (cnt == 3'h4) begin
          seen <= {bus_data_oe, bus_data_out};
          done <= 1'b1;
          busy <= 1'b0;
        end
      end else if (go) begin
        diag_strobe <= 1'b1;
        bus_data_in <= ctrl;
      end else begin
        bus_data_in <= ~bus_data_in;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/memory_ctrl_diag_functions_1_3_test.sv */
// Self-checking bench for the diagnostic function handler
`timescale 1ns/10ps
`default_nettype none
module memory_ctrl_diag_functions_1_3_test;
  import diag_pkg::*;
  localparam logic [3:0] TCODE = 4'h9; // arbitrary identification value
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic go = 1'b0;
  logic [0:4] unit_id = 5'h11;
  logic [0:35] ctrl = '0;
  logic [0:35] bdin, bdout, w, s;
  logic oe, lb_en, offline, done;
  logic [1:0] lb_grp, init_state, ewi;
  prom_sel_t prom_sel;
  fixed_entry_t fv_entry;
  logic [7:0] prom_data = 8'h00, sig_data = 8'h00, arr = 8'h00, a;
  logic [7:0] fv_addr = 8'h00;
  logic [4:0] sig_sel;
  logic [2:0] perr = 3'h0, dv;
  logic strobe, ack;
  logic [36:0] seen;
  logic [36:0] expq[$];
  int miscompares = 0, checks = 0, seed = 97646;
  diag_ctrl #(.TYPE_CODE(TCODE), .FV_DEPTH(256)) i_dut (.clk(clk),
    .sys_rst(sys_rst), .unit_id(unit_id), .diag_strobe(strobe),
    .bus_data_in(bdin), .bus_data_out(bdout), .bus_data_oe(oe),
    .loopback_en(lb_en), .loopback_group(lb_grp), .init_state(init_state),
    .offline(offline), .prom_sel(prom_sel), .prom_data(prom_data),
    .diag_sig_sel(sig_sel), .diag_sig_data(sig_data),
    .error_word_index(ewi), .array_address_register(arr),
    .timing_ram_parity_error(perr[0]), .spare_ram_parity_error(perr[1]),
    .addr_response_ram_parity_error(perr[2]), .fv_addr(fv_addr),
    .fv_entry(fv_entry));
  diag_host_model i_host (.clk(clk), .sys_rst(sys_rst), .go(go),
    .ctrl(ctrl), .bus_data_out(bdout), .bus_data_oe(oe),
    .diag_strobe(strobe), .bus_data_in(bdin), .seen(seen), .done(done));
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  task automatic check(string name, logic [36:0] got, logic [36:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [0:35] cw(logic [4:0] fn);
    cw = '0;
    cw[FN_LO:FN_HI] = fn;
    cw[UNIT_LO:UNIT_HI] = unit_id;
  endfunction
  // Note the expectation, start one cycle, wait for the host to sample
  task automatic diag(logic [0:35] cword, logic [0:35] st, logic en);
    int i;
    expq.push_back({en, st});
    ctrl = cword;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    for (i = 0; i < 20 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  // Compare each sampled status with the oldest noted expectation
  always @(posedge clk) begin
    if (done === 1'b1) begin
      check("status", seen, expq.pop_front());
    end
  end
  // Watchdog; the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    check("reset", 37'({oe, init_state, offline, lb_en}), 37'h0);
    // Each group with its own nonzero init state, offline toggled
    for (int g = 0; g < 3; g++) begin
      w = cw(FN_LOOP);
      w[LB_EN] = 1'b1;
      w[LB_GRP_LO:LB_GRP_HI] = 2'(g);
      w[COND_WE] = 1'b1;
      w[INIT_LO:INIT_HI] = 2'(g + 1);
      w[OFFL] = g[0];
      s = '0;
      s[TYPE_LO:TYPE_HI] = TCODE;
      s[LB_EN:LB_GRP_HI] = {1'b1, 2'(g)};
      // Readback shows the state held before this cycle's update
      s[OFFL:INIT_HI] = {g == 2, 2'(g)};
      diag(w, s, 1'b1);
      check("loop", 37'({lb_en, lb_grp, init_state, offline}),
        37'({1'b1, 2'(g), 2'(g + 1), g[0]}));
    end
    // Condition field ignored without its write enable
    w = cw(FN_LOOP);
    s = '0;
    s[TYPE_LO:TYPE_HI] = TCODE;
    s[INIT_LO:INIT_HI] = 2'h3;
    diag(w, s, 1'b1);
    w[UNIT_LO:UNIT_HI] = ~unit_id;
    w[OFFL] = 1'b1;
    diag(w, '0, 1'b0);
    check("other unit", 37'(offline), 37'h0);
    // PROM and signal readout with one new parity error each time
    for (int k = 0; k < 3; k++) begin
      {prom_data, sig_data, arr} = 24'($random(seed));
      ewi = 2'($random(seed));
      perr = 3'(1 << k);
      @(posedge clk);
      #1 perr = 3'h0;
      w = cw(FN_PROM);
      w[PROM_GRP_LO:PROM_WD_HI] = {2'(k), 4'($random(seed))};
      w[SIG_SEL_LO:SIG_SEL_HI] = 5'(k * 11);
      s = '0;
      s[ERRWD_LO:ERRWD_HI] = ewi;
      s[PDATA_LO:PDATA_HI] = (k == 0) ? prom_data : sig_data;
      s[ARR_LO:ARR_HI] = arr;
      s[TIM_ERR:ADDR_ERR] = 3'({3'h7, 3'h0} >> (k + 1));
      diag(w, s, 1'b1);
      check("prom sel", 37'({prom_sel, sig_sel}),
        37'({w[PROM_GRP_LO:PROM_WD_HI], w[SIG_SEL_LO:SIG_SEL_HI]}));
    end
    s = '0;
    s[CRAM_SUM] = 1'b1;
    diag(cw(FN_ERR), s, 1'b1);
    // Clear still reports the old flags, the next read sees them gone
    w = cw(FN_ERR);
    w[ERR_CLR] = 1'b1;
    diag(w, s, 1'b1);
    diag(cw(FN_ERR), '0, 1'b1);
    // Load both RAMs, read back, then load acknowledge only
    for (int k = 0; k < 4; k++) begin
      {a, ack, dv} = 12'($random(seed));
      w = cw(FN_FIXED);
      w[FV_LO:FV_HI] = a;
      w[ACK_BIT:DV_WE] = {ack, dv, 2'h3};
      s = '0;
      s[ACK_BIT:DV_HI] = {ack, dv};
      diag(w, s, 1'b1);
      w[ACK_BIT:DV_WE] = {~ack, ~dv, 2'h0};
      diag(w, s, 1'b1);
      w[ACK_BIT:DV_WE] = {~ack, ~dv, 2'h2};
      s[ACK_BIT] = ~ack;
      diag(w, s, 1'b1);
      fv_addr = a;
      @(posedge clk);
      #1 check("entry", 37'(fv_entry), 37'({~ack, dv}));
    end
    // Mid-run reset returns the state flags to power-up values
    sys_rst = 1'b1;
    @(posedge clk);
    #1 sys_rst = 1'b0;
    check("rerun", 37'({oe, init_state, offline, lb_en}), 37'h0);
    diag(cw(5'h04), '0, 1'b1);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
`default_nettype wire
